// ### src/operator_panel_control.v
// Operator panel switch decoding, sequencing requests and lamps
`timescale 1ns/1ps
`include "panel_consts.vh"
module operator_panel_control #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter LOCAL_DENSITY   = 1'b1
) (
  // Clock and reset
  input  wire CLK_SYS,
  input  wire ARST_N,
  // Membrane switches, active low from the panel
  input  wire SW_PWR_OFF_N,
  input  wire SW_PWR_ON_N,
  input  wire SW_LOAD_REWIND_N,
  input  wire SW_UNLOAD_N,
  // Transport status, asynchronous to this clock
  input  wire BREAKER_ON,
  input  wire RING_PRESENT,
  input  wire AT_TAPE_START,
  input  wire TAPE_THREADED,
  input  wire TAPE_LOADED,
  input  wire MOTION_DONE,
  // Read/write requests from the formatter
  input  wire WRITE_REQ,
  input  wire READ_REQ,
  // Power and motion outputs
  output reg  DC_POWER_EN,
  output reg  LOAD_START,
  output reg  REWIND_START,
  output reg  UNLOAD_START,
  output reg  SLOW_UNLOAD_START,
  output reg  SPEED_25IPS_SEL,
  output reg  WRITE_ENABLE,
  output reg  READ_ENABLE,
  // Lamps
  output reg  LAMP_PWR_OFF,
  output reg  LAMP_PWR_ON,
  output reg  LAMP_FILE_PROTECT,
  output reg  TAPE_START_MARKER_LAMP,
  output reg  LAMP_HIGH_DENSITY,
  output reg  GROUP_CODED_DENSITY
);

  // Three-stage synchronisers on all asynchronous inputs
  localparam NIN = 10;
  wire [NIN-1:0] raw = {MOTION_DONE, TAPE_LOADED, TAPE_THREADED, AT_TAPE_START,
                        RING_PRESENT, BREAKER_ON, ~SW_UNLOAD_N, ~SW_LOAD_REWIND_N,
                        ~SW_PWR_ON_N, ~SW_PWR_OFF_N};
  reg  [NIN-1:0] s1_r;
  reg  [NIN-1:0] s2_r;
  reg  [NIN-1:0] s3_r;
  reg  [NIN-1:0] in_r;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_r <= {NIN{1'b0}};
      s2_r <= {NIN{1'b0}};
      s3_r <= {NIN{1'b0}};
      in_r <= {NIN{1'b0}};
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts once stages two and three agree
      in_r <= (s2_r & s3_r) | (in_r & (s2_r | s3_r));
    end
  end

  wire breaker_on  = in_r[`IN_BREAKER];
  wire ring        = in_r[`IN_RING];
  wire at_start    = in_r[`IN_AT_START];
  wire threaded    = in_r[`IN_THREADED];
  wire loaded      = in_r[`IN_LOADED];
  wire motion_done = in_r[`IN_MOTION_DONE];

  // Completion edge; a level left high by the last motion must not end the next one
  reg  done_q_r;
  wire done_rise = motion_done && !done_q_r;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      done_q_r <= 1'b0;
    end else begin
      done_q_r <= motion_done;
    end
  end

  // Switch debounce: a level must hold for the full count before it is accepted
  reg  [`CNT_W-1:0] cnt_r [0:`SW_COUNT-1];
  reg  [`SW_COUNT-1:0] deb_r;
  reg  [`SW_COUNT-1:0] press_r;
  integer i;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      deb_r   <= {`SW_COUNT{1'b0}};
      press_r <= {`SW_COUNT{1'b0}};
      for (i = 0; i < `SW_COUNT; i = i + 1)
        cnt_r[i] <= {`CNT_W{1'b0}};
    end else begin
      for (i = 0; i < `SW_COUNT; i = i + 1) begin
        press_r[i] <= 1'b0;
        if (in_r[i] == deb_r[i]) begin
          cnt_r[i] <= {`CNT_W{1'b0}};
        end else if (cnt_r[i] == DEBOUNCE_CYCLES[`CNT_W-1:0] - 1'b1) begin
          cnt_r[i]   <= {`CNT_W{1'b0}};
          deb_r[i]   <= in_r[i];
          press_r[i] <= in_r[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + 1'b1;
        end
      end
    end
  end

  // Motion sequencing: at most one request pulse per accepted press
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE: begin
        if (DC_POWER_EN && press_r[`SW_LOAD] && !(LOCAL_DENSITY && at_start && loaded)) begin
          if (loaded)
            state_nxt = `ST_REWIND;
          else if (threaded)
            state_nxt = `ST_LOAD;
        end else if (DC_POWER_EN && press_r[`SW_UNLOAD] && (loaded || threaded)) begin
          state_nxt = `ST_UNLOAD;
        end
      end
      `ST_LOAD, `ST_REWIND, `ST_UNLOAD: begin
        if (done_rise)
          state_nxt = `ST_IDLE;
      end
      default: state_nxt = `ST_IDLE;
    endcase
  end

  // Sequencer state register
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= `ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power control; off beats a same-cycle on press only while powered (unpowered, on wins), and losing the breaker drops power
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      DC_POWER_EN  <= 1'b0;
      LAMP_PWR_ON  <= 1'b0;
      LAMP_PWR_OFF <= 1'b1;
    end else begin
      if (press_r[`SW_PWR_OFF] && DC_POWER_EN)
        DC_POWER_EN <= 1'b0;
      else if (press_r[`SW_PWR_ON] && breaker_on)
        DC_POWER_EN <= 1'b1;
      else if (!breaker_on)
        DC_POWER_EN <= 1'b0;
      LAMP_PWR_ON  <= DC_POWER_EN;
      LAMP_PWR_OFF <= !DC_POWER_EN;
    end
  end

  // Start pulses on entry to each motion state, one cycle each
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      LOAD_START        <= 1'b0;
      REWIND_START      <= 1'b0;
      UNLOAD_START      <= 1'b0;
      SLOW_UNLOAD_START <= 1'b0;
    end else begin
      LOAD_START        <= state_r == `ST_IDLE && state_nxt == `ST_LOAD;
      REWIND_START      <= state_r == `ST_IDLE && state_nxt == `ST_REWIND;
      UNLOAD_START      <= state_r == `ST_IDLE && state_nxt == `ST_UNLOAD && loaded;
      SLOW_UNLOAD_START <= state_r == `ST_IDLE && state_nxt == `ST_UNLOAD && !loaded;
    end
  end

  // Speed mode is forced after any load or rewind finishes
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      SPEED_25IPS_SEL <= 1'b0;
    end else begin
      if ((state_r == `ST_LOAD || state_r == `ST_REWIND) && done_rise)
        SPEED_25IPS_SEL <= 1'b1;
      else if (state_nxt == `ST_UNLOAD || !DC_POWER_EN)
        SPEED_25IPS_SEL <= 1'b0;
    end
  end

  // Local density toggle only while parked at tape start
  // Group coded after reset, matching the lamp test at power up
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      GROUP_CODED_DENSITY <= 1'b1;
      LAMP_HIGH_DENSITY   <= 1'b1;
    end else begin
      if (LOCAL_DENSITY && DC_POWER_EN && state_r == `ST_IDLE && at_start && loaded
          && press_r[`SW_LOAD])
        GROUP_CODED_DENSITY <= !GROUP_CODED_DENSITY;
      LAMP_HIGH_DENSITY <= GROUP_CODED_DENSITY;
    end
  end

  // Writes gated by the ring; reads never are
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      WRITE_ENABLE           <= 1'b0;
      READ_ENABLE            <= 1'b0;
      LAMP_FILE_PROTECT      <= 1'b1;
      TAPE_START_MARKER_LAMP <= 1'b0;
    end else begin
      WRITE_ENABLE           <= DC_POWER_EN && ring && WRITE_REQ;
      READ_ENABLE            <= DC_POWER_EN && READ_REQ;
      LAMP_FILE_PROTECT      <= !ring;
      TAPE_START_MARKER_LAMP <= at_start;
    end
  end

endmodule

// ### src/panel_consts.vh
// Constants for the operator panel control block
`ifndef PANEL_CONSTS_VH
`define PANEL_CONSTS_VH
`define DEBOUNCE_US      10
`define CLK_MHZ          200
`define DEBOUNCE_CYCLES  (`DEBOUNCE_US * `CLK_MHZ)
`define CNT_W            12
`define SW_COUNT         4
`define SW_PWR_OFF       0
`define SW_PWR_ON        1
`define SW_LOAD          2
`define SW_UNLOAD        3
`define ST_IDLE          2'h0
`define ST_LOAD          2'h1
`define ST_REWIND        2'h2
`define ST_UNLOAD        2'h3
`define IN_BREAKER       4
`define IN_RING          5
`define IN_AT_START      6
`define IN_THREADED      7
`define IN_LOADED        8
`define IN_MOTION_DONE   9
`endif

// ### verif/operator_panel_control_props.sv
// Assertions for the operator panel block
`timescale 1ns/1ps
module panel_props (
  input wire CLK_SYS, ARST_N, RING_PRESENT, WRITE_ENABLE, LAMP_FILE_PROTECT, DC_POWER_EN,
  input wire READ_REQ, READ_ENABLE, LAMP_PWR_ON, LAMP_PWR_OFF, GROUP_CODED_DENSITY,
  input wire LAMP_HIGH_DENSITY, LOAD_START, REWIND_START, MOTION_DONE, SPEED_25IPS_SEL
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // Async inputs pass a synchroniser, so lamps get a few cycles
  wire gc = GROUP_CODED_DENSITY;
  sequence s_go; LOAD_START || REWIND_START; endsequence
  sequence s_end; MOTION_DONE[*8]; endsequence
  a_no_ring: assert property (!RING_PRESENT[*6] |-> !WRITE_ENABLE && LAMP_FILE_PROTECT)
    else $error("write without ring");
  a_read_free: assert property (DC_POWER_EN && READ_REQ ##1 DC_POWER_EN |-> READ_ENABLE)
    else $error("read blocked");
  a_on_lamp: assert property (DC_POWER_EN[*3] |-> LAMP_PWR_ON && !LAMP_PWR_OFF)
    else $error("power lamp wrong");
  a_off_lamp: assert property (!DC_POWER_EN[*3] |-> LAMP_PWR_OFF && !LAMP_PWR_ON)
    else $error("standby lamp wrong");
  a_hd_lamp: assert property ($stable(gc)[*2] |-> LAMP_HIGH_DENSITY == gc)
    else $error("density lamp wrong");
  a_one_load: assert property (LOAD_START |=> !LOAD_START) else $error("double load");
  a_load_power: assert property (LOAD_START |-> DC_POWER_EN) else $error("load unpowered");
  a_speed_set: assert property (s_go ##[1:40] s_end |-> SPEED_25IPS_SEL)
    else $error("speed not set");
endmodule
bind operator_panel_control panel_props u_props (.*);

// ### verif/operator_panel_control_test.sv
// Self-checking bench for the operator panel block
`timescale 1ns/1ps
module operator_panel_control_test;
  logic CLK_SYS = 0, ARST_N = 0, BREAKER_ON = 0, RING_PRESENT = 0, TAPE_THREADED = 0;
  logic WRITE_REQ = 1, READ_REQ = 1, away = 0;
  logic [3:0] sw = 4'hf;
  wire TAPE_LOADED, MOTION_DONE, at_r, DC_POWER_EN, LOAD_START, REWIND_START, UNLOAD_START;
  wire SLOW_UNLOAD_START, SPEED_25IPS_SEL, WRITE_ENABLE, READ_ENABLE, LAMP_PWR_OFF, LAMP_PWR_ON;
  wire LAMP_FILE_PROTECT, TAPE_START_MARKER_LAMP, LAMP_HIGH_DENSITY, GROUP_CODED_DENSITY;
  wire AT_TAPE_START = at_r & !away;
  int failures = 0, n_checks = 0, np[4];
  // Short debounce keeps presses brief
  operator_panel_control #(.DEBOUNCE_CYCLES(4)) uut (.SW_PWR_OFF_N(sw[0]), .SW_PWR_ON_N(sw[1]),
    .SW_LOAD_REWIND_N(sw[2]), .SW_UNLOAD_N(sw[3]), .*);
  tape_motion_model model (.*);
  always #2.5 CLK_SYS = ~CLK_SYS;
  // Pulses by kind: load, rewind, unload, slow unload
  always @(posedge CLK_SYS) if (LOAD_START | REWIND_START | UNLOAD_START | SLOW_UNLOAD_START)
    np[{UNLOAD_START | SLOW_UNLOAD_START, REWIND_START | SLOW_UNLOAD_START}]++;
  task chk(input string n, input logic e, input logic s);
    n_checks++;
    failures += (s !== e);
    if (s !== e) $display("BAD %s expected %b seen %b", n, e, s);
  endtask
  // Both levels held well past sync and debounce
  task press(input int k);
    np = '{default: 0};
    sw[k] = 0;
    repeat (20) @(negedge CLK_SYS);
    sw[k] = 1;
    repeat (60) @(negedge CLK_SYS);
  endtask
  task test_done;
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog far past the eight hundred cycles needed
  initial begin
    #50000 failures++;
    test_done;
  end
  initial begin
    repeat (4) @(negedge CLK_SYS);
    ARST_N = 1;
    press(1);
    chk("power", 0, DC_POWER_EN);
    chk("off lamp", 1, LAMP_PWR_OFF);
    BREAKER_ON = 1;
    press(1);
    chk("power", 1, DC_POWER_EN);
    chk("on lamp", 1, LAMP_PWR_ON);
    chk("read", 1, READ_ENABLE);
    chk("protect", 1, LAMP_FILE_PROTECT);
    chk("write", 0, WRITE_ENABLE);
    TAPE_THREADED = 1;
    press(2);
    chk("load", 1, np[0] == 1);
    chk("speed", 1, SPEED_25IPS_SEL);
    chk("marker", 1, TAPE_START_MARKER_LAMP);
    for (int i = 0; i < 2; i++) begin
      press(2);
      chk("density", i[0], GROUP_CODED_DENSITY);
    end
    chk("hd lamp", 1, LAMP_HIGH_DENSITY);
    RING_PRESENT = 1;
    press(3);
    chk("protect", 0, LAMP_FILE_PROTECT);
    chk("write", 1, WRITE_ENABLE);
    chk("unload", 1, np[2] == 1);
    press(3);
    chk("slow unload", 1, np[3] == 1);
    press(2);
    away = 1;
    press(2);
    chk("rewind", 1, np[1] == 1);
    press(0);
    chk("power", 0, DC_POWER_EN);
    test_done;
  end
endmodule

// ### verif/tape_motion_model.sv
// Behavioural transport motion seen by the panel
`timescale 1ns/1ps
module tape_motion_model (
  input wire CLK_SYS, ARST_N, LOAD_START, REWIND_START, UNLOAD_START, SLOW_UNLOAD_START,
  output logic TAPE_LOADED, MOTION_DONE, at_r
);
  logic [5:0] n_r;
  // Done drops on a start so no stale completion shows; unloads answer slowly
  always @(posedge CLK_SYS or negedge ARST_N)
    if (!ARST_N) {TAPE_LOADED, MOTION_DONE, at_r, n_r} <= 9'h080;
    else if (LOAD_START | REWIND_START | UNLOAD_START | SLOW_UNLOAD_START) begin
      {TAPE_LOADED, MOTION_DONE, at_r} <= {LOAD_START | REWIND_START, 2'h0};
      n_r <= (UNLOAD_START | SLOW_UNLOAD_START) ? 6'h14 : 6'h03;
    end else if (n_r != 6'h00) begin
      n_r <= n_r - 6'h01;
      if (n_r == 6'h01) {MOTION_DONE, at_r} <= {1'h1, TAPE_LOADED};
    end
endmodule
